// [design/nvm_guard_pkg.sv]
package nvm_guard_pkg;

  // Lock register field positions.
  localparam int BOOT_LOCK_HI = 7;
  localparam int BOOT_LOCK_LO = 6;
  localparam int APP_LOCK_HI = 5;
  localparam int APP_LOCK_LO = 4;
  localparam int TABLE_LOCK_HI = 3;
  localparam int TABLE_LOCK_LO = 2;
  localparam int PROG_LOCK_HI = 1;
  localparam int PROG_LOCK_LO = 0;

  // Lock register value after a chip erase: every field unlocked.
  localparam logic [7:0] LOCK_ERASED = 8'h_ff;
  // Bits that software may write; the programmer lock field is excluded.
  localparam logic [7:0] SW_WRITE_MASK = 8'h_fc;

  // Two-bit lock codes shared by all fields.
  localparam logic [1:0] CODE_UNLOCKED = 2'h_3;
  localparam logic [1:0] CODE_WRITE_LOCKED = 2'h_2;
  localparam logic [1:0] CODE_READ_LOCKED = 2'h_1;
  localparam logic [1:0] CODE_READ_WRITE_LOCKED = 2'h_0;

  // Fuse defaults at reset: keep-EEPROM fuse unprogrammed, lowest threshold.
  localparam logic EEPROM_KEEP_PROGRAMMED = 1'b0;
  localparam logic EEPROM_KEEP_DEFAULT = 1'b1;
  localparam logic [2:0] BROWNOUT_CODE_DEFAULT = 3'h_7;
  // Highest threshold code, the one that maps to the lowest voltage.
  localparam logic [2:0] BROWNOUT_MAX_CODE = 3'h_7;

  // Fuse write data layout: keep-EEPROM fuse and threshold code.
  localparam int FUSE_KEEP_BIT = 3;
  localparam int FUSE_LEVEL_HI = 2;
  localparam int FUSE_LEVEL_LO = 0;

  // Fuse write time-out and its cycle count at 125 MHz.
  localparam int CLK_PERIOD_NS = 8;
  localparam int FUSE_WRITE_TIMEOUT_NS = 2000;
  localparam int FUSE_WRITE_CYCLES = (FUSE_WRITE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  // Brown-out threshold in tens of millivolts: code 7 gives 160, step 20.
  localparam logic [8:0] BROWNOUT_MV10_AT_MAX_CODE = 9'h_0a0;
  localparam logic [8:0] BROWNOUT_MV10_STEP = 9'h_014;

  // Program memory sections.
  typedef enum logic [1:0] {
    SECT_APP = 2'b00,
    SECT_TABLE = 2'b01,
    SECT_BOOT = 2'b10
  } section_t;

endpackage : nvm_guard_pkg

// [design/lock_field.sv]
`timescale 1ns/1ns
// One two-bit lock field that moves only toward stricter codes except on erase, which reopens it.
module lock_field (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // Control.
  input wire logic erase,
  input wire logic wr_en,
  input wire logic [1:0] wr_data,
  // State.
  output logic [1:0] code
);

  // Writes AND into the stored code, so only an erase returns a cleared bit to one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      code <= nvm_guard_pkg::CODE_UNLOCKED;
    end else if (clk_en) begin
      if (erase) begin
        code <= nvm_guard_pkg::CODE_UNLOCKED;
      end else if (wr_en) begin
        code <= code & wr_data;
      end
    end
  end

endmodule : lock_field

// [design/sync3.sv]
`timescale 1ns/1ns
// Three-stage synchroniser; the output changes once stages two and three agree.
module sync3 (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic din,
  output logic dout
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Stage one feeds only stage two, keeping metastability away from logic.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

endmodule : sync3

// [design/nvm_lock_and_erase_guard.sv]
`timescale 1ns/1ns
module nvm_lock_and_erase_guard (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // Software access to the lock register in I/O space.
  input wire logic io_lock_wr,
  input wire logic [7:0] io_lock_wdata,
  output logic [7:0] io_lock_rdata,
  // Programming interface requests.
  input wire logic prog_mode,
  input wire logic prog_chip_erase,
  input wire logic prog_mem_write,
  input wire logic prog_mem_read,
  input wire logic prog_fuse_write,
  input wire logic prog_fuse_read,
  input wire logic prog_lock_write,
  input wire logic prog_lock_read,
  input wire logic [7:0] prog_wdata,
  output logic prog_grant,
  output logic prog_refused,
  output logic [7:0] prog_rdata,
  // Programming interface fuse state.
  output logic eeprom_keep_fuse,
  output logic [2:0] brownout_threshold_code,
  output logic fuse_busy,
  // Chip erase outputs, one-cycle pulses.
  output logic erase_flash,
  output logic erase_sram,
  output logic erase_eeprom,
  // CPU program-memory accesses.
  input wire logic cpu_access,
  input wire logic cpu_store,
  input wire logic [1:0] cpu_target_sect,
  input wire logic [1:0] cpu_exec_sect,
  input wire logic vectors_in_boot,
  output logic cpu_allow,
  output logic cpu_block,
  output logic irq_disable,
  // Brown-out detector and power-on reset.
  input wire logic supply_ok_async,
  output logic [2:0] brownout_active_code,
  output logic [8:0] brownout_mv10,
  output logic device_reset_n
);

  logic [1:0] boot_code;
  logic [1:0] app_code;
  logic [1:0] table_code;
  logic [1:0] prog_code;
  logic [1:0] prog_eff;
  logic chip_erase;
  logic lock_wr_sw;
  logic lock_wr_prog;
  logic [7:0] lock_wdata;
  logic prog_wr_lock_ok;
  logic mem_wr_ok;
  logic mem_rd_ok;
  logic fuse_wr_ok;
  logic cfg_rd_ok;
  logic req_any;
  logic req_ok;
  logic supply_ok;
  logic prog_mode_reg;
  logic fuse_keep_pending_reg;
  logic fuse_keep_pending_next;
  logic [2:0] fuse_level_reg;
  logic [nvm_guard_pkg::TIMER_W-1:0] fuse_timer_reg;
  logic [7:0] lock_state;
  logic in_boot;
  logic in_app;
  logic tgt_boot;
  logic tgt_app;
  logic tgt_table;
  logic blocked;

  localparam int TIMER_W_L = nvm_guard_pkg::TIMER_W;
  localparam logic [TIMER_W_L-1:0] FUSE_CYCLES =
    TIMER_W_L'(nvm_guard_pkg::FUSE_WRITE_CYCLES);

  // The read-locked programmer code is treated as the strictest one.
  assign prog_eff = (prog_code == nvm_guard_pkg::CODE_READ_LOCKED) ?
    nvm_guard_pkg::CODE_READ_WRITE_LOCKED : prog_code;

  // Access permissions for the programming interface.
  assign mem_wr_ok = (prog_eff == nvm_guard_pkg::CODE_UNLOCKED);
  assign fuse_wr_ok = (prog_eff == nvm_guard_pkg::CODE_UNLOCKED);
  assign mem_rd_ok = (prog_eff != nvm_guard_pkg::CODE_READ_WRITE_LOCKED);
  assign cfg_rd_ok = (prog_eff != nvm_guard_pkg::CODE_READ_WRITE_LOCKED);
  // Lock writes only tighten, so they stay allowed except under full lock.
  assign prog_wr_lock_ok = (prog_eff != nvm_guard_pkg::CODE_READ_WRITE_LOCKED);

  // Chip erase is always honoured, since it is the only way out of a lock.
  assign chip_erase = prog_mode && prog_chip_erase;
  assign lock_wr_prog = prog_mode && prog_lock_write && prog_wr_lock_ok;
  assign lock_wr_sw = io_lock_wr && !lock_wr_prog;
  // Software cannot touch the programmer lock: those bits are forced to one.
  assign lock_wdata = lock_wr_prog ? prog_wdata :
    (io_lock_wdata | ~nvm_guard_pkg::SW_WRITE_MASK);

  assign req_any = prog_mode && (prog_mem_write || prog_mem_read || prog_fuse_write ||
    prog_fuse_read || prog_lock_write || prog_lock_read);
  assign req_ok = (prog_mem_write && mem_wr_ok) || (prog_mem_read && mem_rd_ok) ||
    (prog_fuse_write && fuse_wr_ok && !fuse_busy) || (prog_fuse_read && cfg_rd_ok) ||
    (prog_lock_write && prog_wr_lock_ok) || (prog_lock_read && cfg_rd_ok);

  // Four lock fields, each tightening only and reopened by chip erase.
  lock_field u_boot (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .erase(chip_erase),
    .wr_en(lock_wr_sw || lock_wr_prog),
    .wr_data(lock_wdata[nvm_guard_pkg::BOOT_LOCK_HI:nvm_guard_pkg::BOOT_LOCK_LO]),
    .code(boot_code)
  );
  lock_field u_app (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .erase(chip_erase),
    .wr_en(lock_wr_sw || lock_wr_prog),
    .wr_data(lock_wdata[nvm_guard_pkg::APP_LOCK_HI:nvm_guard_pkg::APP_LOCK_LO]),
    .code(app_code)
  );
  lock_field u_table (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .erase(chip_erase),
    .wr_en(lock_wr_sw || lock_wr_prog),
    .wr_data(lock_wdata[nvm_guard_pkg::TABLE_LOCK_HI:nvm_guard_pkg::TABLE_LOCK_LO]),
    .code(table_code)
  );
  lock_field u_prog (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .erase(chip_erase),
    .wr_en(lock_wr_prog),
    .wr_data(lock_wdata[nvm_guard_pkg::PROG_LOCK_HI:nvm_guard_pkg::PROG_LOCK_LO]),
    .code(prog_code)
  );

  assign lock_state = {boot_code, app_code, table_code, prog_code};

  // Software read view of the lock register, registered for a clean output.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      io_lock_rdata <= nvm_guard_pkg::LOCK_ERASED;
    end else if (clk_en) begin
      io_lock_rdata <= lock_state;
    end
  end

  // Programming interface answer; refused requests return zero data.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prog_grant <= 1'b0;
      prog_refused <= 1'b0;
      prog_rdata <= 8'h_00;
    end else if (clk_en) begin
      prog_grant <= req_any && req_ok;
      prog_refused <= req_any && !req_ok;
      if (prog_mode && prog_lock_read && cfg_rd_ok) begin
        prog_rdata <= lock_state;
      end else if (prog_mode && prog_fuse_read && cfg_rd_ok) begin
        prog_rdata <= {4'h_0, eeprom_keep_fuse, fuse_level_reg};
      end else begin
        prog_rdata <= 8'h_00;
      end
    end
  end

  // A keep fuse write waits out the time-out before the new value applies.
  assign fuse_keep_pending_next = prog_wdata[nvm_guard_pkg::FUSE_KEEP_BIT];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fuse_timer_reg <= '0;
      fuse_busy <= 1'b0;
      fuse_keep_pending_reg <= nvm_guard_pkg::EEPROM_KEEP_DEFAULT;
      fuse_level_reg <= nvm_guard_pkg::BROWNOUT_CODE_DEFAULT;
      eeprom_keep_fuse <= nvm_guard_pkg::EEPROM_KEEP_DEFAULT;
    end else if (clk_en) begin
      if (prog_mode && prog_fuse_write && fuse_wr_ok && !fuse_busy) begin
        fuse_timer_reg <= FUSE_CYCLES;
        fuse_busy <= 1'b1;
        fuse_keep_pending_reg <= fuse_keep_pending_next;
        fuse_level_reg <= prog_wdata[nvm_guard_pkg::FUSE_LEVEL_HI:nvm_guard_pkg::FUSE_LEVEL_LO];
      end else if (fuse_busy) begin
        if (fuse_timer_reg == TIMER_W_L'(1)) begin
          fuse_busy <= 1'b0;
          eeprom_keep_fuse <= fuse_keep_pending_reg;
        end
        fuse_timer_reg <= fuse_timer_reg - TIMER_W_L'(1);
      end
    end
  end

  always_comb begin
    brownout_threshold_code = fuse_level_reg;
  end

  // Chip erase pulses; EEPROM is spared while the keep fuse reads zero.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      erase_flash <= 1'b0;
      erase_sram <= 1'b0;
      erase_eeprom <= 1'b0;
    end else if (clk_en) begin
      erase_flash <= chip_erase;
      erase_sram <= chip_erase;
      erase_eeprom <= chip_erase &&
        (eeprom_keep_fuse != nvm_guard_pkg::EEPROM_KEEP_PROGRAMMED);
    end
  end

  // The detector picks up a new threshold only when programming mode ends.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prog_mode_reg <= 1'b0;
      brownout_active_code <= nvm_guard_pkg::BROWNOUT_CODE_DEFAULT;
    end else if (clk_en) begin
      prog_mode_reg <= prog_mode;
      if (prog_mode_reg && !prog_mode) begin
        brownout_active_code <= fuse_level_reg;
      end
    end
  end

  // Nominal threshold: 1.6 V at code 7, 0.2 V higher per lower code.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      brownout_mv10 <= nvm_guard_pkg::BROWNOUT_MV10_AT_MAX_CODE;
    end else if (clk_en) begin
      brownout_mv10 <= nvm_guard_pkg::BROWNOUT_MV10_AT_MAX_CODE + 9'(
        (nvm_guard_pkg::BROWNOUT_MAX_CODE - brownout_active_code) *
        nvm_guard_pkg::BROWNOUT_MV10_STEP);
    end
  end

  // The analog comparator output arrives unsynchronised.
  sync3 u_supply_sync (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .din(supply_ok_async),
    .dout(supply_ok)
  );

  // Device reset stays asserted until supply passes the threshold once.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      device_reset_n <= 1'b0;
    end else if (clk_en) begin
      if (supply_ok) begin
        device_reset_n <= 1'b1;
      end
    end
  end

  // Section decode for the CPU check.
  assign in_boot = (cpu_exec_sect == nvm_guard_pkg::SECT_BOOT);
  assign in_app = (cpu_exec_sect != nvm_guard_pkg::SECT_BOOT);
  assign tgt_boot = (cpu_target_sect == nvm_guard_pkg::SECT_BOOT);
  assign tgt_app = (cpu_target_sect == nvm_guard_pkg::SECT_APP);
  assign tgt_table = (cpu_target_sect == nvm_guard_pkg::SECT_TABLE);

  // Store blocked by clear bit 0, load across the boot boundary blocked by clear bit 1.
  always_comb begin
    blocked = 1'b0;
    if (cpu_store) begin
      blocked = (tgt_boot && !boot_code[0]) || (tgt_app && !app_code[0]) ||
        (tgt_table && !table_code[0]);
    end else begin
      blocked = (tgt_boot && in_app && !boot_code[1]) ||
        (tgt_app && in_boot && !app_code[1]) ||
        (tgt_table && in_boot && !table_code[1]);
    end
  end

  // Access verdict and interrupt masking, registered.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_allow <= 1'b0;
      cpu_block <= 1'b0;
      irq_disable <= 1'b0;
    end else if (clk_en) begin
      cpu_allow <= cpu_access && !blocked;
      cpu_block <= cpu_access && blocked;
      irq_disable <= (in_boot && !vectors_in_boot && !boot_code[1]) ||
        (in_app && vectors_in_boot && (!app_code[1] || !table_code[1]));
    end
  end

endmodule : nvm_lock_and_erase_guard

// [verif/nvm_guard_asserts.sv]
`timescale 1ns/1ns
// Port-level checks of the guard; the lock byte is sampled one cycle after a request,
// which is when the read-back shows the field value that the request was judged on.
module nvm_guard_asserts (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // Programming side.
  input wire logic prog_mode,
  input wire logic prog_mem_write,
  input wire logic prog_mem_read,
  input wire logic prog_fuse_write,
  input wire logic prog_grant,
  input wire logic prog_refused,
  input wire logic [7:0] io_lock_rdata,
  input wire logic eeprom_keep_fuse,
  input wire logic fuse_busy,
  input wire logic erase_flash,
  input wire logic erase_eeprom,
  // Brown-out.
  input wire logic supply_ok_async,
  input wire logic [2:0] brownout_active_code,
  input wire logic [8:0] brownout_mv10,
  input wire logic device_reset_n,
  // CPU side.
  input wire logic cpu_access,
  input wire logic cpu_store,
  input wire logic [1:0] cpu_target_sect,
  input wire logic [1:0] cpu_exec_sect,
  input wire logic vectors_in_boot,
  input wire logic cpu_allow,
  input wire logic cpu_block,
  input wire logic irq_disable
);
  default clocking dc @(posedge mclk);
  endclocking
  // A frozen clock enable holds all state, so no cycle-based check applies then.
  default disable iff (!rstn || !clk_en);

  // Programmer access decisions against the lock byte and the fuse busy flag, and keep fuse timing.
  mem_read_a: assert property (prog_mode && prog_mem_read |=>
    prog_refused == !io_lock_rdata[1] && prog_grant == io_lock_rdata[1])
    else $error("memory read decision wrong");
  mem_write_a: assert property (prog_mode && prog_mem_write |=>
    prog_refused == (io_lock_rdata[1:0] != 2'b11)) else $error("memory write decision wrong");
  busy_refuse_a: assert property (prog_mode && prog_fuse_write && fuse_busy |=>
    prog_refused) else $error("fuse write taken while busy");
  keep_timing_a: assert property ($changed(eeprom_keep_fuse) |-> $fell(fuse_busy))
    else $error("keep fuse moved outside time-out end");
  // Erase outputs and lock monotonicity.
  erase_keep_a: assert property (erase_eeprom |->
    erase_flash && $past(eeprom_keep_fuse)) else $error("eeprom erased while kept");
  lock_rise_a: assert property ((io_lock_rdata & ~$past(io_lock_rdata)) != 8'h00 |->
    $past(erase_flash)) else $error("lock bit released without erase");
  // Brown-out threshold mapping and update timing.
  volts_map_a: assert property (brownout_mv10 == 9'h0a0 +
    9'h014 * (9'h007 - {6'h00, $past(brownout_active_code)})) else $error("threshold map wrong");
  active_hold_a: assert property ($past(prog_mode, 2) && $past(prog_mode) && prog_mode |->
    $stable(brownout_active_code)) else $error("threshold changed in session");
  power_up_a: assert property ($rose(device_reset_n) |-> $past(supply_ok_async, 3))
    else $error("reset released before supply good");
  // CPU access and interrupt masking.
  boot_store_a: assert property (cpu_access && cpu_store &&
    cpu_target_sect == nvm_guard_pkg::SECT_BOOT |=> cpu_block == !io_lock_rdata[6] &&
    cpu_allow == io_lock_rdata[6]) else $error("boot store decision wrong");
  irq_boot_a: assert property (cpu_exec_sect == nvm_guard_pkg::SECT_BOOT &&
    !vectors_in_boot |=> irq_disable == !io_lock_rdata[7]) else $error("boot irq mask wrong");

  cover property (erase_eeprom);
  cover property (prog_mode && prog_mem_read ##1 prog_refused);
  cover property (cpu_access ##1 cpu_block);
endmodule : nvm_guard_asserts

bind nvm_lock_and_erase_guard nvm_guard_asserts u_chk (.mclk, .rstn, .clk_en, .prog_mode,
  .prog_mem_write, .prog_mem_read, .prog_fuse_write, .prog_grant, .prog_refused,
  .io_lock_rdata, .eeprom_keep_fuse, .fuse_busy, .erase_flash, .erase_eeprom,
  .supply_ok_async, .brownout_active_code, .brownout_mv10, .device_reset_n, .cpu_access,
  .cpu_store, .cpu_target_sect, .cpu_exec_sect, .vectors_in_boot, .cpu_allow, .cpu_block,
  .irq_disable);

// [verif/prog_model.sv]
`timescale 1ns/1ns
// External programmer: one pulsed request per call, answer taken one cycle later.
module prog_model (
  // Clock.
  input wire logic mclk,
  // Requests.
  output logic prog_mode,
  output logic [6:0] rq,
  output logic [7:0] prog_wdata,
  // Answer.
  input wire logic prog_grant,
  input wire logic prog_refused,
  input wire logic [7:0] prog_rdata
);
  logic g;
  logic r;
  logic [7:0] rd;

  // Idle state at time zero.
  initial begin
    prog_mode = 1'b0;
    rq = 7'h00;
    prog_wdata = 8'h00;
  end

  // Enter or leave the programming session.
  task automatic mode(input logic m);
    @(negedge mclk);
    prog_mode = m;
  endtask : mode

  // Only this side ever asks for a programmer lock write.
  task automatic req(input int k, input logic [7:0] d);
    @(negedge mclk);
    rq = 7'h01 << k;
    prog_wdata = d;
    @(negedge mclk);
    // The answer stands for one cycle only, so it is taken before the release.
    g = prog_grant;
    r = prog_refused;
    rd = prog_rdata;
    rq = 7'h00;
    prog_wdata = ~d; // Released data must not look valid.
    @(negedge mclk);
  endtask : req
endmodule : prog_model

// [verif/nvm_lock_and_erase_guard_test.sv]
`timescale 1ns/1ns
// Self-checking bench for the lock and erase guard.
module nvm_lock_and_erase_guard_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic io_lock_wr = 1'b0;
  logic [7:0] io_lock_wdata = 8'h00;
  logic cpu_access = 1'b0;
  logic cpu_store = 1'b0;
  logic [1:0] cpu_target_sect = 2'h0;
  logic [1:0] cpu_exec_sect = 2'h0;
  logic vectors_in_boot = 1'b0;
  logic supply_ok_async = 1'b0;
  wire logic prog_mode, prog_grant, prog_refused, eeprom_keep_fuse, fuse_busy;
  wire logic erase_flash, erase_sram, erase_eeprom, cpu_allow, cpu_block, irq_disable;
  wire logic device_reset_n;
  wire logic [6:0] rq;
  wire logic [7:0] prog_wdata, prog_rdata, io_lock_rdata;
  wire logic [2:0] brownout_threshold_code, brownout_active_code;
  wire logic [8:0] brownout_mv10;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0000_df60;
  logic [7:0] lk;
  logic [7:0] w;
  logic [2:0] fc;
  logic kp;
  logic b;
  logic q;

  nvm_lock_and_erase_guard dut (.mclk, .rstn, .clk_en, .io_lock_wr, .io_lock_wdata,
    .io_lock_rdata, .prog_mode, .prog_chip_erase(rq[0]), .prog_mem_write(rq[1]),
    .prog_mem_read(rq[2]), .prog_fuse_write(rq[3]), .prog_fuse_read(rq[4]),
    .prog_lock_write(rq[5]), .prog_lock_read(rq[6]), .prog_wdata, .prog_grant,
    .prog_refused, .prog_rdata, .eeprom_keep_fuse, .brownout_threshold_code, .fuse_busy,
    .erase_flash, .erase_sram, .erase_eeprom, .cpu_access, .cpu_store, .cpu_target_sect,
    .cpu_exec_sect, .vectors_in_boot, .cpu_allow, .cpu_block, .irq_disable,
    .supply_ok_async, .brownout_active_code, .brownout_mv10, .device_reset_n);
  prog_model pm (.mclk, .prog_mode, .rq, .prog_wdata, .prog_grant, .prog_refused,
    .prog_rdata);

  always #4 mclk = ~mclk;

  // Cuts a hang short; the full run needs about three thousand cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 8000) begin
      errors++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : rnd

  // Nominal threshold in tens of millivolts for a code.
  function automatic logic [8:0] mv(input logic [2:0] c);
    return 9'h0a0 + 9'h014 * (9'h007 - {6'h00, c});
  endfunction : mv

  // A store needs write freedom; a load across the boot boundary needs read freedom.
  function automatic logic blk(input logic [1:0] t, input logic [1:0] e, input logic s,
    input logic [7:0] l);
    logic [1:0] f;
    f = (t == 2'h2) ? l[7:6] : (t == 2'h1) ? l[3:2] : l[5:4];
    if (s) return !f[0];
    return !f[1] && ((t == 2'h2) != (e == 2'h2));
  endfunction : blk

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic sw(input logic [7:0] d);
    @(negedge mclk);
    io_lock_wr = 1'b1;
    io_lock_wdata = d;
    @(negedge mclk);
    io_lock_wr = 1'b0;
    io_lock_wdata = ~d;
    repeat (2) @(negedge mclk);
  endtask : sw

  task automatic test_done();
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Main sequence: reset, fuse codes with erase, then random lock traffic.
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    chk("lock reset", io_lock_rdata, 8'hff);
    chk("mv reset", brownout_mv10, mv(3'h7));
    chk("held reset", device_reset_n, 1'b0);
    supply_ok_async = 1'b1;
    repeat (8) @(negedge mclk);
    chk("released", device_reset_n, 1'b1);
    pm.mode(1'b1);
    for (int c = 0; c < 8; c++) begin
      fc = c[2:0];
      kp = c[0];
      pm.req(3, {4'h0, kp, fc});
      chk("fuse grant", pm.g, 1'b1);
      chk("busy", fuse_busy, 1'b1);
      chk("threshold", brownout_threshold_code, fc);
      pm.req(3, 8'h0f);
      chk("busy refuse", pm.r, 1'b1);
      chk("active held", brownout_active_code, c == 0 ? 3'h7 : fc - 3'h1);
      repeat (nvm_guard_pkg::FUSE_WRITE_CYCLES) @(negedge mclk);
      chk("keep", eeprom_keep_fuse, kp);
      chk("idle", fuse_busy, 1'b0);
      // The erase pulses stand for one cycle, across the request's second falling edge, where they are checked.
      fork
        pm.req(0, 8'h00);
        begin
          repeat (2) @(negedge mclk);
          chk("erase", {erase_flash, erase_sram, erase_eeprom}, {2'b11, kp});
        end
      join
      pm.mode(1'b0);
      repeat (3) @(negedge mclk);
      chk("active", brownout_active_code, fc);
      chk("volts", brownout_mv10, mv(fc));
      pm.mode(1'b1);
    end
    lk = 8'hff;
    for (int i = 0; i < 24; i++) begin
      seed = rnd(seed);
      w = seed[7:0];
      if (seed[8]) begin
        sw(w);
        lk = lk & (w | 8'h03);
      end else begin
        pm.req(5, w);
        chk("lock wr", pm.r, !lk[1]);
        if (lk[1]) lk = lk & w;
        repeat (2) @(negedge mclk);
      end
      chk("lock byte", io_lock_rdata, lk);
      pm.req(6, 8'h00);
      chk("lock rd", {pm.g, pm.rd}, {lk[1], lk[1] ? lk : 8'h00});
      pm.req(2, 8'h00);
      chk("mem rd", pm.r, !lk[1]);
      pm.req(1, 8'h00);
      chk("mem wr", pm.r, lk[1:0] != 2'h3);
      pm.req(4, 8'h00);
      chk("fuse rd", {pm.g, pm.rd}, {lk[1], lk[1] ? 8'h0f : 8'h00});
      if (lk[1:0] != 2'h3) begin
        pm.req(3, 8'h00);
        chk("fuse wr", pm.r, 1'b1);
      end
      seed = rnd(seed);
      @(negedge mclk);
      cpu_access = 1'b1;
      cpu_store = seed[0];
      cpu_target_sect = (seed[2:1] == 2'h3) ? 2'h0 : seed[2:1];
      cpu_exec_sect = {seed[3], 1'b0};
      vectors_in_boot = seed[4];
      b = blk(cpu_target_sect, cpu_exec_sect, cpu_store, lk);
      q = (seed[3] && !seed[4] && !lk[7]) || (!seed[3] && seed[4] && !(lk[5] && lk[3]));
      @(negedge mclk);
      chk("cpu", {cpu_allow, cpu_block, irq_disable}, {!b, b, q});
      cpu_access = 1'b0;
      @(negedge mclk);
      if (i % 4 == 3) begin
        pm.req(0, 8'h00);
        lk = 8'hff;
        repeat (2) @(negedge mclk);
      end
    end
    // Frozen clock enable: a software write must leave no trace, even after the thaw.
    @(negedge mclk) clk_en = 1'b0;
    sw(8'h00);
    chk("frozen", io_lock_rdata, lk);
    @(negedge mclk) clk_en = 1'b1;
    repeat (2) @(negedge mclk);
    chk("thawed", io_lock_rdata, lk);
    test_done();
  end
endmodule : nvm_lock_and_erase_guard_test
